// ==== core/ecp_pkg.sv ====
// shared constants and types for the external control port
package ecp_pkg;
	// ********************************
	// register map
	// ********************************
	localparam logic [7:0] ECP_CTRL_OFF   = 8'h00;
	localparam logic [7:0] ECP_STATE_OFF  = 8'h04;
	localparam logic [7:0] ECP_STATUS_OFF = 8'h08;
	localparam logic [7:0] ECP_EVENT_OFF  = 8'h0c;
	// ctrl fields
	localparam int ECP_CTRL_MODE  = 0;
	localparam int ECP_CTRL_POL   = 2;
	localparam int ECP_CTRL_REM   = 3;
	localparam int ECP_CTRL_FUNC  = 4;
	localparam int ECP_CTRL_QC    = 6;
	localparam int ECP_CTRL_PER   = 8;
	// state fields
	localparam int ECP_ST_PROT    = 0;
	localparam int ECP_ST_LIM     = 1;
	localparam int ECP_ST_CAL     = 2;
	localparam int ECP_ST_BUSY    = 3;
	localparam int ECP_ST_R200    = 4;
	localparam int ECP_ST_STEP1   = 5;
	localparam int ECP_ST_STEP2   = 6;
	// reset values
	localparam logic [31:0] ECP_CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] ECP_STATE_RST = 32'h0000_0008;
	localparam logic [10:0] ECP_IN_IDLE   = 11'h7ff;
	// ********************************
	// timing
	// ********************************
	localparam int ECP_CLK_MHZ  = 100;
	localparam int ECP_TICK_MS  = 10;
	localparam int ECP_TICK_CYC = ECP_TICK_MS * 1000 * ECP_CLK_MHZ;
	// ********************************
	// event bits, also input order
	// ********************************
	localparam int ECP_EV_OFF   = 0;
	localparam int ECP_EV_ON    = 1;
	localparam int ECP_EV_START = 2;
	localparam int ECP_EV_STOP  = 3;
	localparam int ECP_EV_HOLD  = 4;
	localparam int ECP_EV_BR1   = 5;
	localparam int ECP_EV_BR2   = 6;
	localparam int ECP_EV_REC   = 7;
	localparam int ECP_EV_PEAK  = 8;
	localparam int ECP_NEV      = 9;
	localparam logic [1:0] ECP_RESP_OK  = 2'h0;
	localparam logic [1:0] ECP_RESP_ERR = 2'h2;
	typedef enum logic [1:0] {
		ECP_MODE_DISABLE, ECP_MODE_ENABLE, ECP_MODE_PERIPH, ECP_MODE_RSVD
	} ecp_mode_t;
	typedef enum logic [1:0] {
		ECP_FN_CONT, ECP_FN_SEQ, ECP_FN_SIM, ECP_FN_RSVD
	} ecp_func_t;
	typedef enum logic [1:0] {
		ECP_SEQ_IDLE, ECP_SEQ_RUN, ECP_SEQ_HOLD
	} ecp_seq_t;
endpackage : ecp_pkg

// ==== core/ecp_port.sv ====
// external control port: pin control inputs, status outputs, axi4-lite
`timescale 1ns/1ps
module ecp_port
	import ecp_pkg::*;
#(
	parameter int TICK_CYCLES = ECP_TICK_CYC
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        out_off_n,
	input  wire logic        out_on_n,
	input  wire logic        seq_start_n,
	input  wire logic        seq_stop_n,
	input  wire logic        seq_hold_n,
	input  wire logic        branch1_n,
	input  wire logic        branch2_n,
	input  wire logic        recall_n,
	input  wire logic        peak_clear_n,
	input  wire logic [1:0]  mem_sel,
	output logic             st_power,
	output logic             st_output,
	output logic             st_protect,
	output logic             st_limit,
	output logic             st_cal,
	output logic             st_busy,
	output logic             st_range,
	output logic             step_sync1,
	output logic             step_sync2,
	output logic             qc_sync,
	output logic [3:0]       periph_ctrl,
	output logic             peak_clear,
	output logic             recall_load
);

	// ********************************
	// helpers
	// ********************************
	function automatic logic pol(input logic act, input logic pos);
		// negative polarity shows an active state as low
		return pos ? act : ~act;
	endfunction : pol

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] d, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// ********************************
	// registers and state
	// ********************************
	logic [31:0]         ctrl;
	logic [31:0]         state_in;
	logic [ECP_NEV-1:0]  events;
	logic                out_on;
	ecp_seq_t            seq;
	logic [1:0]          rec_mem;
	ecp_func_t           rec_type;
	logic                rec_compile;
	logic                qc_req;
	logic [31:0]         tick_cnt;
	logic                tick;
	logic [10:0]         sync1;
	logic [10:0]         sync2;
	logic [10:0]         sample;
	logic [10:0]         prev;
	logic [ECP_NEV-1:0]  fall;
	logic                accept;
	ecp_mode_t           mode;
	ecp_func_t           func;
	logic                pol_pos;
	logic                aw_held;
	logic                w_held;
	logic [7:0]          aw_addr;
	logic [31:0]         w_data;
	logic [3:0]          w_be;
	logic                do_wr;
	logic                wr_hit;
	logic [ECP_NEV-1:0]  ev_clr;

	assign mode    = ecp_mode_t'(ctrl[ECP_CTRL_MODE +: 2]);
	assign func    = ecp_func_t'(ctrl[ECP_CTRL_FUNC +: 2]);
	assign pol_pos = ctrl[ECP_CTRL_POL];

	// ********************************
	// 10 ms tick
	// ********************************
	assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt <= 32'h0000_0000;
		end else if (tick) begin
			tick_cnt <= 32'h0000_0000;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
		end
	end

	// ********************************
	// pin sampling and edge detection
	// ********************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= ECP_IN_IDLE;
			sync2 <= ECP_IN_IDLE;
		end else begin
			sync1 <= {mem_sel, peak_clear_n, recall_n, branch2_n,
				branch1_n, seq_hold_n, seq_stop_n, seq_start_n,
				out_on_n, out_off_n};
			sync2 <= sync1;
		end
	end

	// pulled-up idle is high, so reset to ones avoids a false edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sample <= ECP_IN_IDLE;
			prev   <= ECP_IN_IDLE;
		end else if (tick) begin
			prev   <= sample;
			sample <= sync2;
		end
	end

	// edges are seen once, in the cycle after the sample moved
	logic sampled;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sampled <= 1'b0;
		end else begin
			sampled <= tick;
		end
	end

	assign fall = prev[ECP_NEV-1:0] & ~sample[ECP_NEV-1:0];
	// mode encoding makes the two port uses exclusive
	assign accept = sampled && mode == ECP_MODE_ENABLE
		&& !ctrl[ECP_CTRL_REM];

	// ********************************
	// output and sequence control
	// ********************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			out_on <= 1'b0;
		end else if (accept && fall[ECP_EV_OFF]) begin
			out_on <= 1'b0;
		end else if (accept && fall[ECP_EV_ON]) begin
			out_on <= 1'b1;
		end
	end

	// stop outranks start and hold when edges coincide
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			seq <= ECP_SEQ_IDLE;
		end else if (accept && func != ECP_FN_CONT) begin
			if (fall[ECP_EV_STOP]) begin
				seq <= ECP_SEQ_IDLE;
			end else if (fall[ECP_EV_HOLD] && seq == ECP_SEQ_RUN) begin
				seq <= ECP_SEQ_HOLD;
			end else if (fall[ECP_EV_START]) begin
				seq <= ECP_SEQ_RUN;
			end
		end
	end

	// ********************************
	// recall and peak clear
	// ********************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rec_mem     <= 2'h0;
			rec_type    <= ECP_FN_CONT;
			rec_compile <= 1'b0;
			recall_load <= 1'b0;
			peak_clear  <= 1'b0;
		end else begin
			recall_load <= accept && fall[ECP_EV_REC];
			peak_clear  <= accept && fall[ECP_EV_PEAK];
			if (accept && fall[ECP_EV_REC]) begin
				// select lines were sampled on the same tick
				rec_mem     <= sample[10:9];
				rec_type    <= func;
				rec_compile <= func != ECP_FN_CONT;
			end
		end
	end

	// ********************************
	// event flags, set wins over clear
	// ********************************
	logic [ECP_NEV-1:0] ev_set;
	always_comb begin
		ev_set = accept ? fall : '0;
		// branches only mean something while a sequence runs
		if (seq != ECP_SEQ_RUN) begin
			ev_set[ECP_EV_BR1] = 1'b0;
			ev_set[ECP_EV_BR2] = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			events <= '0;
		end else begin
			events <= (events & ~ev_clr) | ev_set;
		end
	end

	// ********************************
	// status pins
	// ********************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_power   <= 1'b0;
			st_output  <= 1'b1;
			st_protect <= 1'b1;
			st_limit   <= 1'b1;
			st_cal     <= 1'b1;
			st_busy    <= 1'b0;
			st_range   <= 1'b1;
			step_sync1 <= 1'b0;
			step_sync2 <= 1'b0;
		end else if (tick) begin
			st_power   <= 1'b1;
			st_output  <= pol(out_on, pol_pos);
			st_protect <= pol(state_in[ECP_ST_PROT], pol_pos);
			st_limit   <= pol(state_in[ECP_ST_LIM], pol_pos);
			st_cal     <= pol(state_in[ECP_ST_CAL], pol_pos);
			st_busy    <= pol(state_in[ECP_ST_BUSY], pol_pos);
			st_range   <= ~state_in[ECP_ST_R200];
			step_sync1 <= state_in[ECP_ST_STEP1];
			step_sync2 <= state_in[ECP_ST_STEP2];
		end
	end

	// ********************************
	// peripheral control
	// ********************************
	// a requested sync pulse lasts one full tick period
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			qc_sync     <= 1'b0;
			periph_ctrl <= 4'h0;
		end else if (mode != ECP_MODE_PERIPH) begin
			qc_sync     <= 1'b0;
			periph_ctrl <= 4'h0;
		end else if (tick) begin
			qc_sync     <= qc_req;
			periph_ctrl <= ctrl[ECP_CTRL_PER +: 4];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			qc_req <= 1'b0;
		end else if (wr_hit && aw_addr == ECP_CTRL_OFF && w_be[0]
				&& w_data[ECP_CTRL_QC]) begin
			qc_req <= 1'b1;
		end else if (tick) begin
			qc_req <= 1'b0;
		end
	end

	// ********************************
	// axi4-lite write side
	// ********************************
	// a new write waits until the previous answer has been taken
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign do_wr  = aw_held && w_held && !s_axi_bvalid;
	assign wr_hit = do_wr;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_be    <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
			end else if (do_wr) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_be   <= s_axi_wstrb;
			end else if (do_wr) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= ECP_RESP_OK;
		end else if (do_wr) begin
			s_axi_bvalid <= 1'b1;
			unique case (aw_addr)
				ECP_CTRL_OFF, ECP_STATE_OFF, ECP_STATUS_OFF,
				ECP_EVENT_OFF: s_axi_bresp <= ECP_RESP_OK;
				default: s_axi_bresp <= ECP_RESP_ERR;
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl     <= ECP_CTRL_RST;
			state_in <= ECP_STATE_RST;
		end else if (do_wr && aw_addr == ECP_CTRL_OFF) begin
			// quick-change request bit is a strobe, not stored
			ctrl <= merge(ctrl, w_data, w_be) & ~(32'h1 << ECP_CTRL_QC);
		end else if (do_wr && aw_addr == ECP_STATE_OFF) begin
			state_in <= merge(state_in, w_data, w_be);
		end
	end

	// write one to clear
	assign ev_clr = (do_wr && aw_addr == ECP_EVENT_OFF)
		? ECP_NEV'(merge(32'h0, w_data, w_be)) : '0;

	// ********************************
	// axi4-lite read side
	// ********************************
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= ECP_RESP_OK;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= ECP_RESP_OK;
			unique case ({s_axi_araddr[7:2], 2'b00})
				ECP_CTRL_OFF:   s_axi_rdata <= ctrl;
				ECP_STATE_OFF:  s_axi_rdata <= state_in;
				ECP_STATUS_OFF: s_axi_rdata <= {24'h0, rec_compile,
					rec_type, rec_mem, seq, out_on};
				ECP_EVENT_OFF:  s_axi_rdata <= 32'(events);
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= ECP_RESP_ERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : ecp_port

// ==== verification/ecp_assertions.sv ====
// concurrent checks on the control port pins and register bus
`timescale 1ns/1ps
module ecp_assertions #(
	parameter int TICK_CYCLES = 20
) (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        st_power,
	input wire logic        st_output,
	input wire logic        st_busy,
	input wire logic        st_range,
	input wire logic        peak_clear,
	input wire logic        recall_load
);
	// ********************************
	// properties
	// ********************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_peak_pulse: assert property (peak_clear |=> !peak_clear)
		else $error("peak clear pulse longer than one cycle");
	a_recall_pulse: assert property (recall_load |=> !recall_load)
		else $error("recall pulse longer than one cycle");
	a_power_holds: assert property (st_power |=> st_power)
		else $error("power status dropped while powered");
	// status only moves on tick edges, ticks are well over 8 apart
	a_status_ticked: assert property (
		!$stable({st_output, st_busy, st_range}) |=>
		$stable({st_output, st_busy, st_range})[*8])
		else $error("status changed between ticks");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken during answer");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	a_write_block: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during answer");
endmodule : ecp_assertions

bind ecp_port ecp_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.clock(clock), .rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.st_power(st_power), .st_output(st_output), .st_busy(st_busy),
	.st_range(st_range), .peak_clear(peak_clear),
	.recall_load(recall_load));

// ==== verification/ecp_ctl_model.sv ====
// external controller model driving the ttl control lines
`timescale 1ns/1ps
module ecp_ctl_model (
	input  wire logic  clock,
	output logic [8:0] lines_n,
	output logic [1:0] sel
);
	// lines idle high, as the pull-ups leave them
	initial begin
		lines_n = 9'h1ff;
		sel     = 2'h0;
	end
	// select set before the line falls, level held two ticks plus margin
	task press(input int idx, input logic [1:0] s, input int tk);
		@(posedge clock);
		sel <= s;
		@(posedge clock);
		lines_n[idx] <= 1'b0;
		repeat (2 * tk + 2) @(posedge clock);
		lines_n[idx] <= 1'b1;
		repeat (2 * tk + 2) @(posedge clock);
		@(negedge clock);
	endtask : press
endmodule : ecp_ctl_model

// ==== verification/tb_ecp_port.sv ====
// self-checking bench for the external control port
`timescale 1ns/1ps
module tb_ecp_port;
	import ecp_pkg::*;
	localparam int T = 20;
	logic clock, rst_n, awv, wv, bready, arv, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, v;
	logic [8:0] ln;
	logic [1:0] sel, resp;
	logic qcs, awr, wr_r, bv, arr, rv, pwr, sout, spro, slim, scal, sbsy;
	logic srng, ss1, ss2, qc, pclr, rld;
	logic [1:0] br, rr;
	logic [31:0] rdata;
	logic [3:0] pctl;
	int n_fail, samples_checked, n_rec, n_pk;
	ecp_ctl_model u_ctl (.clock(clock), .lines_n(ln), .sel(sel));
	ecp_port #(.TICK_CYCLES(T)) dut (.clock(clock), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rready), .out_off_n(ln[0]),
		.out_on_n(ln[1]), .seq_start_n(ln[2]), .seq_stop_n(ln[3]),
		.seq_hold_n(ln[4]), .branch1_n(ln[5]), .branch2_n(ln[6]),
		.recall_n(ln[7]), .peak_clear_n(ln[8]), .mem_sel(sel),
		.st_power(pwr), .st_output(sout), .st_protect(spro),
		.st_limit(slim), .st_cal(scal), .st_busy(sbsy), .st_range(srng),
		.step_sync1(ss1), .step_sync2(ss2), .qc_sync(qc),
		.periph_ctrl(pctl), .peak_clear(pclr), .recall_load(rld));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		n_rec <= n_rec + int'(rld);
		n_pk  <= n_pk + int'(pclr);
	end
	// ********************************
	// bus and compare tasks
	// ********************************
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
		do begin
			@(negedge clock);
			@(posedge clock);
			if (awr) awv <= 1'b0;
			if (wr_r) wv <= 1'b0;
		end while (!(awr && wr_r) && (awv || wv));
		do @(negedge clock); while (!bv);
		resp = br;
		@(posedge clock);
		bready <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clock);
		araddr <= a; arv <= 1'b1; rready <= 1'b1;
		do @(negedge clock); while (!arr);
		@(posedge clock);
		arv <= 1'b0;
		do @(negedge clock); while (!rv);
		v = rdata; resp = rr;
		@(posedge clock);
		rready <= 1'b0;
	endtask : rd
	task ev(input logic [31:0] e);
		rd(ECP_EVENT_OFF);
		chk(v, e);
		wr(ECP_EVENT_OFF, 32'h0000_01ff);
	endtask : ev
	task wt(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask : wt
	// ********************************
	// scenarios
	// ********************************
	task t_bus;
		chk({pwr, sout, sbsy, srng}, 32'h5);
		rd(ECP_CTRL_OFF);   chk(v, ECP_CTRL_RST);
		rd(ECP_STATE_OFF);  chk(v, ECP_STATE_RST);
		rd(8'h10);          chk(v, 32'h0);
		chk(resp, ECP_RESP_ERR);
		wr(8'h10, 32'h1);   chk(resp, ECP_RESP_ERR);
	endtask : t_bus
	task t_idle;
		wr(ECP_CTRL_OFF, 32'h0);
		u_ctl.press(ECP_EV_ON, 2'h0, T);
		ev(32'h0);
		chk(pwr, 1'b1);
		wr(ECP_CTRL_OFF, 32'h9);
		u_ctl.press(ECP_EV_ON, 2'h0, T);
		ev(32'h0);
	endtask : t_idle
	task t_output;
		wr(ECP_CTRL_OFF, 32'h1);
		u_ctl.press(ECP_EV_ON, 2'h0, T);
		chk(sout, 1'b0);
		wr(ECP_CTRL_OFF, 32'h5);
		wt(2 * T + 2);
		chk(sout, 1'b1);
		u_ctl.press(ECP_EV_OFF, 2'h0, T);
		chk(sout, 1'b0);
		ev(32'h3);
	endtask : t_output
	task t_status;
		for (int p = 0; p < 2; p++) begin
			wr(ECP_CTRL_OFF, 32'(1 + 4 * p));
			wr(ECP_STATE_OFF, 32'h7f);
			wt(2 * T + 2);
			chk({spro, slim, scal, sbsy, srng, ss1, ss2}, {{4{p[0]}}, 3'h3});
			wr(ECP_STATE_OFF, 32'h0);
			wt(2 * T + 2);
			chk({spro, slim, scal, sbsy, srng, ss1, ss2}, {{4{!p[0]}}, 3'h4});
		end
	endtask : t_status
	task t_seq;
		wr(ECP_CTRL_OFF, 32'h21);
		u_ctl.press(ECP_EV_START, 2'h0, T);
		rd(ECP_STATUS_OFF); chk(v[2:1], 2'h1);
		u_ctl.press(ECP_EV_BR1, 2'h0, T);
		u_ctl.press(ECP_EV_HOLD, 2'h0, T);
		rd(ECP_STATUS_OFF); chk(v[2:1], 2'h2);
		u_ctl.press(ECP_EV_START, 2'h0, T);
		u_ctl.press(ECP_EV_BR2, 2'h0, T);
		u_ctl.press(ECP_EV_STOP, 2'h0, T);
		rd(ECP_STATUS_OFF); chk(v[2:1], 2'h0);
		ev(32'h7c);
	endtask : t_seq
	task t_recall;
		for (int f = 0; f < 3; f++) begin
			wr(ECP_CTRL_OFF, 32'(1 + 16 * f));
			u_ctl.press(ECP_EV_REC, 2'(3 - f), T);
			rd(ECP_STATUS_OFF);
			chk(v[7:3], {f != 0, 2'(f), 2'(3 - f)});
		end
		chk(n_rec, 3);
		u_ctl.press(ECP_EV_PEAK, 2'h0, T);
		chk(n_pk, 1);
		ev(32'h180);
	endtask : t_recall
	task t_periph;
		wr(ECP_CTRL_OFF, 32'ha02);
		wt(T + 2);
		chk(pctl, 4'ha);
		u_ctl.press(ECP_EV_ON, 2'h0, T);
		ev(32'h0);
		qcs = 1'b0;
		wr(ECP_CTRL_OFF, 32'ha42);
		repeat (3 * T) @(negedge clock) qcs |= qc;
		chk(qcs, 1'b1);
	endtask : t_periph
	task test_done;
		$display("checked=%0d failed=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done
	initial begin
		rst_n = 1'b0; awv = 1'b0; wv = 1'b0; bready = 1'b0; arv = 1'b0;
		rready = 1'b0; awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0;
		n_fail = 0; samples_checked = 0; n_rec = 0; n_pk = 0;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		@(negedge clock);
		t_bus; t_idle; t_output; t_status; t_seq; t_recall; t_periph;
		test_done;
	end
	// hang guard, roughly six times the expected run
	initial begin
		#100000;
		n_fail++;
		test_done;
	end
endmodule : tb_ecp_port
